// ### design/abd_defines.svh
// constants: register map, field positions, reset values and timing counts
// What this block does
// - add-literal adds 8-bit literal to accumulator, result to accumulator, updates carry, digit carry, zero
// - add-file adds accumulator and addressed file register, updating carry, digit carry and zero
// - file add/AND results go to accumulator when dest is 0, file when 1
// - AND-file ANDs accumulator with file register, routes by dest, updates Z only
// - AND-literal ANDs accumulator with literal into accumulator, updates Z only
// - bit-clear zeroes one selected bit of file register, flags untouched
// - bit-set forces one selected bit of file register to one, flags untouched
// - every instruction completes in one instruction cycle of four clocks
`ifndef ABD_DEFINES_SVH
`define ABD_DEFINES_SVH

// avalon byte addresses
`define ABD_ADDR_W 10
`define ABD_OFF_CMD 10'h000
`define ABD_OFF_ACC 10'h004
`define ABD_OFF_STATUS 10'h008
`define ABD_OFF_RESULT 10'h00c
`define ABD_OFF_FILE 10'h200
`define ABD_FILE_DEPTH 128

// command word fields
`define ABD_CMD_LIT_LSB 0
`define ABD_CMD_FADDR_LSB 8
`define ABD_CMD_DEST_BIT 15
`define ABD_CMD_BIT_LSB 16
`define ABD_CMD_OP_LSB 20

// operation codes
`define ABD_OP_ADD_LIT 3'h0
`define ABD_OP_ADD_FILE 3'h1
`define ABD_OP_AND_FILE 3'h2
`define ABD_OP_AND_LIT 3'h3
`define ABD_OP_CLR_BIT 3'h4
`define ABD_OP_SET_BIT 3'h5

// status word bits
`define ABD_ST_C 0
`define ABD_ST_DIGIT_CARRY 1
`define ABD_ST_Z 2
`define ABD_ST_BUSY 8
`define ABD_ST_BADOP 9

// result word fields
`define ABD_RES_TOFILE_BIT 8
`define ABD_RES_FADDR_LSB 9

// reset values
`define ABD_ACC_RESET 8'h00
`define ABD_FILE_RESET 8'h00

// clocks per instruction cycle
`define ABD_CLKS_PER_INSTR 4

`endif

// ### design/abd_pkg.sv
// types shared by the datapath and its alu
`include "abd_defines.svh"

package abd_pkg;

	// execution phases, one clock each
	typedef enum logic [2:0] {
		ABD_IDLE,
		ABD_Q1,
		ABD_Q2,
		ABD_Q3,
		ABD_Q4
	} abd_phase_t;

	// register selected by a bus address
	typedef enum logic [2:0] {
		ABD_SEL_CMD,
		ABD_SEL_ACC,
		ABD_SEL_STATUS,
		ABD_SEL_RESULT,
		ABD_SEL_FILE,
		ABD_SEL_NONE
	} abd_sel_t;

	// one decoded instruction
	typedef struct packed {
		logic [2:0] op;
		logic [2:0] bit_sel;
		logic dest;
		logic [6:0] faddr;
		logic [7:0] lit;
	} abd_cmd_t;

	// alu answer and where it goes
	typedef struct packed {
		logic [7:0] result;
		logic carry;
		logic dcarry;
		logic zero;
		logic upd_cdc;
		logic upd_z;
		logic to_acc;
		logic to_file;
		logic bad_op;
	} abd_alu_out_t;

endpackage : abd_pkg

// ### design/abd_alu.sv
// combinational alu for add, AND and single-bit clear/set
`timescale 1ns/1ps
`default_nettype none
`include "abd_defines.svh"

module abd_alu
	import abd_pkg::*;
(
	input wire abd_cmd_t cmd,
	input wire logic [7:0] acc,
	input wire logic [7:0] fval,
	output var abd_alu_out_t res
);

	// one-hot mask of the selected bit
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction : bit_mask

	logic [8:0] sum_lit;
	logic [8:0] sum_file;
	logic [4:0] nib_lit;
	logic [4:0] nib_file;

	// carries come from 9-bit and 5-bit sums
	assign sum_lit = {1'b0, acc} + {1'b0, cmd.lit};
	assign sum_file = {1'b0, acc} + {1'b0, fval};
	assign nib_lit = {1'b0, acc[3:0]} + {1'b0, cmd.lit[3:0]};
	assign nib_file = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};

	// operation select; codes 6 and 7 write nothing back and only raise bad_op
	always_comb begin
		res = '0;
		unique case (cmd.op)
			`ABD_OP_ADD_LIT: begin
				res.result = sum_lit[7:0];
				res.carry = sum_lit[8];
				res.dcarry = nib_lit[4];
				res.upd_cdc = 1'b1;
				res.upd_z = 1'b1;
				res.to_acc = 1'b1;
			end
			`ABD_OP_ADD_FILE: begin
				res.result = sum_file[7:0];
				res.carry = sum_file[8];
				res.dcarry = nib_file[4];
				res.upd_cdc = 1'b1;
				res.upd_z = 1'b1;
				res.to_acc = ~cmd.dest;
				res.to_file = cmd.dest;
			end
			`ABD_OP_AND_FILE: begin
				res.result = acc & fval;
				res.upd_z = 1'b1;
				res.to_acc = ~cmd.dest;
				res.to_file = cmd.dest;
			end
			`ABD_OP_AND_LIT: begin
				res.result = acc & cmd.lit;
				res.upd_z = 1'b1;
				res.to_acc = 1'b1;
			end
			`ABD_OP_CLR_BIT: begin
				res.result = fval & ~bit_mask(cmd.bit_sel);
				res.to_file = 1'b1;
			end
			`ABD_OP_SET_BIT: begin
				res.result = fval | bit_mask(cmd.bit_sel);
				res.to_file = 1'b1;
			end
			default: begin
				res.bad_op = 1'b1;
			end
		endcase
		res.zero = (res.result == 8'h00);
	end

endmodule : abd_alu
`default_nettype wire

// ### design/abd_top.sv
// add/AND/bit datapath with its file registers behind an avalon-mm slave
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "abd_defines.svh"

module abd_top
	import abd_pkg::*;
#(
	parameter int FILE_DEPTH = `ABD_FILE_DEPTH
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [`ABD_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic busy
);

	// index width of the file; a depth of one still needs one bit
	localparam int IDX_W = (FILE_DEPTH > 1) ? $clog2(FILE_DEPTH) : 1;

	// all state of the block in one record; the file lives in flops,
	// which costs area but lets one cycle read and write any entry
	typedef struct packed {
		logic [FILE_DEPTH-1:0][7:0] file;
		logic [7:0] acc;
		logic c;
		logic digit_carry_flag;
		logic z;
		logic bad_op;
		abd_cmd_t cmd;
		logic [7:0] fval;
		abd_phase_t phase;
		logic busy;
		logic [7:0] last_result;
		logic last_to_file;
		logic [6:0] last_faddr;
		logic waitrequest;
		logic [31:0] rdata;
	} abd_state_t;

	// registered record and the value it takes at the next edge
	abd_state_t s;
	abd_state_t next_s;
	abd_alu_out_t alu;

	// byte address to register; file window is word per entry
	function automatic abd_sel_t decode(input logic [`ABD_ADDR_W-1:0] a);
		logic [`ABD_ADDR_W-1:0] rel;
		// below the window rel wraps high, which the >= test screens out
		rel = a - `ABD_OFF_FILE;
		if (a == `ABD_OFF_CMD) begin
			decode = ABD_SEL_CMD;
		end else if (a == `ABD_OFF_ACC) begin
			decode = ABD_SEL_ACC;
		end else if (a == `ABD_OFF_STATUS) begin
			decode = ABD_SEL_STATUS;
		end else if (a == `ABD_OFF_RESULT) begin
			decode = ABD_SEL_RESULT;
		end else if (a >= `ABD_OFF_FILE && rel[1:0] == 2'b00
				&& (32'(rel) >> 2) < 32'(FILE_DEPTH)) begin
			decode = ABD_SEL_FILE;
		end else begin
			decode = ABD_SEL_NONE;
		end
	endfunction : decode

	// file index carried by a byte address inside the window
	function automatic logic [IDX_W-1:0] file_index(
		input logic [`ABD_ADDR_W-1:0] a
	);
		logic [`ABD_ADDR_W-1:0] rel;
		rel = (a - `ABD_OFF_FILE) >> 2;
		file_index = IDX_W'(rel);
	endfunction : file_index

	// byte lanes of a 32-bit write
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction : merge

	// command register as a bus word
	function automatic logic [31:0] cmd_word(input abd_cmd_t c);
		cmd_word = '0;
		cmd_word[`ABD_CMD_LIT_LSB +: 8] = c.lit;
		cmd_word[`ABD_CMD_FADDR_LSB +: 7] = c.faddr;
		cmd_word[`ABD_CMD_DEST_BIT] = c.dest;
		cmd_word[`ABD_CMD_BIT_LSB +: 3] = c.bit_sel;
		cmd_word[`ABD_CMD_OP_LSB +: 3] = c.op;
	endfunction : cmd_word

	// file entry, zero when the address lies past the storage
	function automatic logic [7:0] file_at(
		input logic [FILE_DEPTH-1:0][7:0] f,
		input logic [6:0] addr
	);
		if (32'(addr) < 32'(FILE_DEPTH)) begin
			file_at = f[IDX_W'(addr)];
		end else begin
			file_at = 8'h00;
		end
	endfunction : file_at

	// status register as a bus word; busy and bad-op sit above the flags
	function automatic logic [31:0] status_word(input abd_state_t st);
		status_word = '0;
		status_word[`ABD_ST_C] = st.c;
		status_word[`ABD_ST_DIGIT_CARRY] = st.digit_carry_flag;
		status_word[`ABD_ST_Z] = st.z;
		status_word[`ABD_ST_BUSY] = st.busy;
		status_word[`ABD_ST_BADOP] = st.bad_op;
	endfunction : status_word

	// last write-back as a bus word, so software can see where it went
	function automatic logic [31:0] result_word(input abd_state_t st);
		result_word = '0;
		result_word[7:0] = st.last_result;
		result_word[`ABD_RES_TOFILE_BIT] = st.last_to_file;
		result_word[`ABD_RES_FADDR_LSB +: 7] = st.last_faddr;
	endfunction : result_word

	// the arithmetic itself lives in the alu; its operands come from
	// flops, so the adder has phases Q2 to Q4 to settle, since fval loads at the end of Q1
	abd_alu u_alu (
		.cmd(s.cmd),
		.acc(s.acc),
		.fval(s.fval),
		.res(alu)
	);

	// read-data mux for the selected register; it is only sampled
	// into rdata on the edge that grants a read
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		unique case (decode(avs_address))
			ABD_SEL_CMD: begin
				rd_mux = cmd_word(s.cmd);
			end
			ABD_SEL_ACC: begin
				rd_mux[7:0] = s.acc;
			end
			ABD_SEL_STATUS: begin
				rd_mux = status_word(s);
			end
			ABD_SEL_RESULT: begin
				rd_mux = result_word(s);
			end
			ABD_SEL_FILE: begin
				rd_mux[7:0] = s.file[file_index(avs_address)];
			end
			ABD_SEL_NONE: begin
				rd_mux = '0;
			end
		endcase
	end

	// next state: bus handshake, register writes, instruction phases
	logic [31:0] cmd_new;
	always_comb begin
		next_s = s;
		// partial command writes keep the byte lanes not enabled
		cmd_new = merge(cmd_word(s.cmd), avs_writedata, avs_byteenable);

		// bus slave: one cycle with waitrequest low per access; the
		// access lands on the edge that ends that cycle, the same edge
		// at which the master sees waitrequest low
		if (!s.waitrequest) begin
			next_s.waitrequest = 1'b1;
			if (avs_write) begin
				unique case (decode(avs_address))
					ABD_SEL_CMD: begin
						next_s.cmd.lit = cmd_new[`ABD_CMD_LIT_LSB +: 8];
						next_s.cmd.faddr = cmd_new[`ABD_CMD_FADDR_LSB +: 7];
						next_s.cmd.dest = cmd_new[`ABD_CMD_DEST_BIT];
						next_s.cmd.bit_sel = cmd_new[`ABD_CMD_BIT_LSB +: 3];
						next_s.cmd.op = cmd_new[`ABD_CMD_OP_LSB +: 3];
						next_s.phase = ABD_Q1;
						next_s.busy = 1'b1;
					end
					ABD_SEL_ACC: begin
						if (avs_byteenable[0]) begin
							next_s.acc = avs_writedata[7:0];
						end
					end
					ABD_SEL_STATUS: begin
						if (avs_byteenable[0]) begin
							next_s.c = avs_writedata[`ABD_ST_C];
							next_s.digit_carry_flag =
								avs_writedata[`ABD_ST_DIGIT_CARRY];
							next_s.z = avs_writedata[`ABD_ST_Z];
						end
						// writing a one clears the bad-op flag
						if (avs_byteenable[1] && avs_writedata[`ABD_ST_BADOP]) begin
							next_s.bad_op = 1'b0;
						end
					end
					ABD_SEL_FILE: begin
						if (avs_byteenable[0]) begin
							next_s.file[file_index(avs_address)] =
								avs_writedata[7:0];
						end
					end
					default: begin
						// result register and holes take writes silently
					end
				endcase
			end
		end else if ((avs_read || avs_write) && s.phase == ABD_IDLE) begin
			// stall the bus while an instruction runs, so software
			// never sees a half-updated accumulator or file
			next_s.waitrequest = 1'b0;
			// capture now so the word stands through the answer cycle
			if (avs_read) begin
				next_s.rdata = rd_mux;
			end
		end

		// four phases per instruction cycle
		unique case (s.phase)
			ABD_IDLE: begin
				// nothing runs; the bus has the block to itself
			end
			ABD_Q1: begin
				// operand fetched before anything is written back
				next_s.fval = file_at(s.file, s.cmd.faddr);
				next_s.phase = ABD_Q2;
			end
			ABD_Q2: begin
				next_s.phase = ABD_Q3;
			end
			ABD_Q3: begin
				next_s.phase = ABD_Q4;
			end
			ABD_Q4: begin
				// write-back and flags land on the last phase
				if (alu.to_acc) begin
					next_s.acc = alu.result;
				end
				// an address past a shallow file is dropped, never wrapped
				if (alu.to_file && 32'(s.cmd.faddr) < 32'(FILE_DEPTH)) begin
					next_s.file[IDX_W'(s.cmd.faddr)] = alu.result;
				end
				// carry and digit carry only move on the adds
				if (alu.upd_cdc) begin
					next_s.c = alu.carry;
					next_s.digit_carry_flag = alu.dcarry;
				end
				if (alu.upd_z) begin
					next_s.z = alu.zero;
				end
				if (alu.bad_op) begin
					next_s.bad_op = 1'b1;
				end
				next_s.last_result = alu.result;
				next_s.last_to_file = alu.to_file;
				next_s.last_faddr = s.cmd.faddr;
				next_s.busy = 1'b0;
				next_s.phase = ABD_IDLE;
			end
			default: begin
				// an unused phase code falls back to idle rather than hang
				next_s.phase = ABD_IDLE;
				next_s.busy = 1'b0;
			end
		endcase
	end

	// state register; clk_en low freezes everything, bus included, so
	// a master simply sees a longer wait; reset acts regardless of it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s <= '0;
			s.file <= {FILE_DEPTH{`ABD_FILE_RESET}};
			s.acc <= `ABD_ACC_RESET;
			s.phase <= ABD_IDLE;
			s.waitrequest <= 1'b1;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// outputs straight from the state flops
	// no logic between flop and pin keeps output timing clean
	assign avs_readdata = s.rdata;
	assign avs_waitrequest = s.waitrequest;
	assign busy = s.busy;

endmodule : abd_top
`default_nettype wire

// ### test/abd_top_properties.sv
// bus timing and instruction length checks for the datapath
`timescale 1ns/1ps
`default_nettype none
`include "abd_defines.svh"

module abd_props (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [`ABD_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// an answered access and an accepted command write
	sequence s_ack;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence
	sequence s_cmd_ack;
		avs_write && !avs_waitrequest && avs_address == `ABD_OFF_CMD;
	endsequence
	// four phases, then idle again
	sequence s_run;
		busy [*4] ##1 !busy;
	endsequence

	property p_busy_len;
		$rose(busy) |-> s_run;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_cmd_start;
		s_cmd_ack |=> s_run;
	endproperty
	a_cmd_start: assert property (p_cmd_start) else $error("no run");
	property p_busy_src;
		$rose(busy) |-> $past(avs_write) && !$past(avs_waitrequest)
			&& $past(avs_address) == `ABD_OFF_CMD;
	endproperty
	a_busy_src: assert property (p_busy_src) else $error("stray busy");
	property p_wait_busy;
		busy |-> avs_waitrequest;
	endproperty
	a_wait_busy: assert property (p_wait_busy) else $error("answer in run");
	property p_ack_pulse;
		s_ack |=> avs_waitrequest;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long answer");
	property p_idle_ack;
		(avs_read || avs_write) && !busy |-> ##[0:8] !avs_waitrequest;
	endproperty
	a_idle_ack: assert property (p_idle_ack) else $error("no answer");
	property p_resume;
		$fell(busy) && (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest;
	endproperty
	a_resume: assert property (p_resume) else $error("late resume");
	property p_stat_idle;
		avs_read && !avs_waitrequest && avs_address == `ABD_OFF_STATUS
			|-> !avs_readdata[`ABD_ST_BUSY];
	endproperty
	a_stat_idle: assert property (p_stat_idle) else $error("busy bit seen");
endmodule : abd_props

bind abd_top abd_props u_props (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.clk_en(clk_en),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.busy(busy)
);
`default_nettype wire

// ### test/abd_top_tb.sv
// self-checking bench for the add/AND/bit datapath
`timescale 1ns/1ps
`default_nettype none

module abd_top_tb;
	logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
	logic avs_waitrequest, busy;
	logic [9:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	int failures = 0, num_checks = 0, cycles = 0, busy_cyc = 0, b0;

	abd_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .busy(busy));

	always #5 sys_clk = ~sys_clk;
	// cycle count for the hang limit and busy length
	always @(posedge sys_clk) begin
		cycles++;
		if (busy === 1'b1) busy_cyc++;
		if (cycles == 5000) begin
			failures++;
			wrap_up();
		end
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one access; held until waitrequest is seen low, idle edge after
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge sys_clk);
	endtask : bus

	task rd(input logic [9:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(q, e);
	endtask : rd

	task op(input logic [2:0] o, input logic [7:0] k, input logic [6:0] f,
		input logic d, input logic [2:0] b);
		bus(1, 10'h000, {9'h0, o, 1'b0, b, d, f, k});
	endtask : op

	task t_add;
		bus(1, 10'h004, 32'h0f);
		b0 = busy_cyc;
		op(0, 8'h01, 0, 0, 0);
		rd(10'h004, 32'h10);
		rd(10'h008, 32'h2);
		chk(busy_cyc - b0, 4);
		op(0, 8'hf0, 0, 0, 0);
		rd(10'h008, 32'h5);
		bus(1, 10'h3fc, 32'h88);
		bus(1, 10'h004, 32'h88);
		op(1, 0, 127, 1, 0);
		rd(10'h3fc, 32'h10);
		rd(10'h00c, 32'hff10);
		rd(10'h004, 32'h88);
		rd(10'h008, 32'h3);
		op(1, 0, 127, 0, 0);
		rd(10'h004, 32'h98);
		rd(10'h008, 32'h0);
	endtask : t_add

	task t_and;
		bus(1, 10'h008, 32'h3);
		op(2, 0, 127, 1, 0);
		rd(10'h3fc, 32'h10);
		rd(10'h008, 32'h3);
		bus(1, 10'h004, 32'h0f);
		op(2, 0, 127, 0, 0);
		rd(10'h004, 32'h0);
		rd(10'h008, 32'h7);
		bus(1, 10'h004, 32'hff);
		op(3, 8'h5a, 0, 0, 0);
		rd(10'h004, 32'h5a);
		rd(10'h008, 32'h3);
		op(3, 8'ha5, 0, 0, 0);
		rd(10'h008, 32'h7);
	endtask : t_and

	// set every bit position from 0 up to 7, then clear them from 0 up to 7; dest bit must not matter
	task t_bits;
		for (int b = 0; b < 8; b++) begin
			op(5, 0, 0, b[0], 3'(b));
			rd(10'h200, 32'(8'((9'h2 << b) - 1)));
		end
		for (int b = 0; b < 8; b++) begin
			op(4, 0, 0, !b[0], 3'(b));
			rd(10'h200, 32'(8'(8'hff << (b + 1))));
		end
		rd(10'h008, 32'h7);
		rd(10'h00c, 32'h100);
		rd(10'h004, 32'h0);
	endtask : t_bits

	// unused op code: flags kept, sticky bad-op raised, then cleared
	task t_misc;
		op(6, 8'h33, 5, 1, 0);
		rd(10'h008, 32'h207);
		rd(10'h00c, 32'ha00);
		rd(10'h000, 32'h608533);
		bus(1, 10'h00c, 32'hffff);
		rd(10'h00c, 32'ha00);
		bus(1, 10'h008, 32'h207);
		rd(10'h008, 32'h7);
		rd(10'h010, 32'h0);
	endtask : t_misc

	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 0;
		@(posedge sys_clk);
		rd(10'h004, 32'h0);
		t_add();
		t_and();
		t_bits();
		t_misc();
		wrap_up();
	end
endmodule : abd_top_tb
`default_nettype wire
